// ---- hw/pbr_ctrl.sv ----
// power button and reset controller: pins and charger insertion to power and reset actions
// assumes all inputs synchronous to clk_sys; command pulses come from the power command register
//
// Function
// - code 0010: rising edge on input one gives hard reset after 200 ms
// - code 0010: rising edge on input two gives soft reset after 200 ms
// - code 0011: falling edges instead, one hard, two soft, after 200 ms
// - codes 0010 to 0101: leave power only by command, never by pins
// - code 0100: high level at charger insertion, hard or soft reset after 200 ms
// - code 0101: low level at charger insertion, hard or soft reset after 200 ms
// - codes 0110, 0111, 1011: input one is key, input two open-drain key mirror
// - code 0110: power on by 400 ms key press or charger insertion
// - code 0110: power off by key held over 12 s or command
// - codes 0111, 1000: power on by key held over 3 s or insertion
// - code 0111: key held over 12 s gives soft reset; off only by command
// - code 1000: input two held low over 12 s gives soft reset, no mirror
// - codes 1001, 1010: power on only by charger insertion
// - code 1001: input one high at insertion starts 15 s hard reset, 10 ms low cancels
// - code 1001: input two high at insertion starts 15 s soft reset, 10 ms low cancels
// - code 1010: inverted polarity of the 15 s countdowns and their cancel
// - code 1011: like key mode, also allows off and seal states
// - code 1100: like 1001 countdowns, also allows off and seal states
// - codes 0000, 0001: input one is 10 ms debounced on/off level, input two soft reset
// - soft reset drives system reset low for 10 ms
// - hard reset launches the full power-on reset sequence
`default_nettype none

`include "pbr_cfg.svh"

module pbr_ctrl #(
    parameter int TICK_CYC = `PBR_TICK_CYC,
    parameter int CNT_W = `PBR_CNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // configuration and register commands
    input wire pbr_pkg::pbr_code_t pin_function_config_code,
    input wire logic power_off_request,
    input wire logic seal_request,
    // pins
    input wire logic power_function_input_one,
    input wire logic power_function_input_two,
    input wire logic charger_supply_input,
    output logic key_mirror_output,
    output logic key_mirror_oe_n,
    // power and reset
    output pbr_pkg::pbr_pwr_t power_state,
    output logic hard_reset,
    output logic sys_reset_n
);
    import pbr_pkg::*;

    typedef logic [CNT_W-1:0] pbr_cnt_t;

    // threshold reached on the step that brought the count there
    function automatic logic hit(input logic stp, input pbr_cnt_t c, input int ms);
        return stp && (c == pbr_cnt_t'(ms));
    endfunction : hit

    // delay before a pending reset fires
    function automatic int delay_ms(input pbr_code_t code);
        return (code >= PBR_AON_RISE && code <= PBR_CR_LO) ? `PBR_RESET_DELAY_MS : `PBR_COUNTDOWN_MS;
    endfunction : delay_ms

    ////////////////////////////////////////////////////////////////////////////
    // timebase

    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt == 32'(TICK_CYC - 1))
        begin
            next_tick_cnt = 32'h0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interval timers

    pbr_code_t code;
    logic pin1;
    logic pin2;
    logic on;
    logic pend_h;
    logic pend_s;
    logic run1;
    logic run2;
    pbr_cnt_t c1, c2, ch, cs, cr;
    logic s1, s2, sh, ss, sr;

    assign code = pin_function_config_code;
    assign pin1 = power_function_input_one;
    assign pin2 = power_function_input_two;
    assign on = (power_state == PBR_ON);

    // qualifying condition of each pin timer
    always_comb
    begin
        run1 = 1'b0;
        run2 = 1'b0;
        unique case (code)
            PBR_ONOFF_HI:
            begin
                run1 = pin1 != on;
                run2 = !pin2 && on;
            end
            PBR_ONOFF_LO:
            begin
                run1 = !pin1 != on;
                run2 = !pin2 && on;
            end
            PBR_KEY, PBR_KEY_SEAL, PBR_CSR_ONE:
            begin
                run1 = !pin1;
            end
            PBR_CSR_TWO:
            begin
                run1 = !pin1;
                run2 = !pin2 && on;
            end
            PBR_CUST_HI, PBR_CUST_SEAL:
            begin
                run1 = pend_h && !pin1;
                run2 = pend_s && !pin2;
            end
            PBR_CUST_LO:
            begin
                run1 = pend_h && pin1;
                run2 = pend_s && pin2;
            end
            default:
            begin
                run1 = 1'b0;
                run2 = 1'b0;
            end
        endcase
    end

    pbr_timer #(.CNT_W(CNT_W)) u_t1 (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick), .run(run1), .count(c1), .step(s1));
    pbr_timer #(.CNT_W(CNT_W)) u_t2 (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick), .run(run2), .count(c2), .step(s2));
    pbr_timer #(.CNT_W(CNT_W)) u_th (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick), .run(pend_h), .count(ch), .step(sh));
    pbr_timer #(.CNT_W(CNT_W)) u_ts (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick), .run(pend_s), .count(cs), .step(ss));
    pbr_timer #(.CNT_W(CNT_W)) u_tr (.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick), .run(!sys_reset_n), .count(cr),
        .step(sr));

    ////////////////////////////////////////////////////////////////////////////
    // power and reset control

    logic p1_q, p2_q, chg_q;
    pbr_pwr_t next_state;
    logic next_pend_h, next_pend_s, next_hard, next_rst_n, next_oe_n;
    logic ins, hard_go, soft_go, seal_ok, pin_on_ok;

    always_comb
    begin
        next_state = power_state;
        next_pend_h = pend_h;
        next_pend_s = pend_s;
        next_hard = 1'b0;
        next_rst_n = sys_reset_n;
        next_oe_n = 1'b1;
        hard_go = 1'b0;
        soft_go = 1'b0;
        ins = charger_supply_input && !chg_q;
        seal_ok = (code == PBR_KEY_SEAL) || (code == PBR_CUST_SEAL);
        pin_on_ok = (code >= PBR_AON_RISE) && (code <= PBR_CUST_SEAL);
        unique case (code)
            PBR_ONOFF_HI, PBR_ONOFF_LO:
            begin
                if (hit(s1, c1, `PBR_DEBOUNCE_MS))
                    next_state = on ? PBR_OFF : PBR_ON;
                if (hit(s2, c2, `PBR_DEBOUNCE_MS))
                    soft_go = 1'b1;
            end
            PBR_AON_RISE:
            begin
                if (pin1 && !p1_q)
                    next_pend_h = 1'b1;
                if (pin2 && !p2_q)
                    next_pend_s = 1'b1;
            end
            PBR_AON_FALL:
            begin
                if (!pin1 && p1_q)
                    next_pend_h = 1'b1;
                if (!pin2 && p2_q)
                    next_pend_s = 1'b1;
            end
            PBR_CR_HI, PBR_CUST_HI, PBR_CUST_SEAL:
            begin
                if (ins && pin1)
                    next_pend_h = 1'b1;
                if (ins && pin2)
                    next_pend_s = 1'b1;
            end
            PBR_CR_LO, PBR_CUST_LO:
            begin
                if (ins && !pin1)
                    next_pend_h = 1'b1;
                if (ins && !pin2)
                    next_pend_s = 1'b1;
            end
            PBR_KEY, PBR_KEY_SEAL:
            begin
                next_oe_n = pin1;
                if (!on && hit(s1, c1, `PBR_SHORT_PRESS_MS))
                    next_state = PBR_ON;
                if (on && hit(s1, c1, `PBR_LONG_PRESS_MS))
                    next_state = PBR_OFF;
            end
            PBR_CSR_ONE:
            begin
                next_oe_n = pin1;
                if (!on && hit(s1, c1, `PBR_ON_PRESS_MS))
                    next_state = PBR_ON;
                if (on && hit(s1, c1, `PBR_LONG_PRESS_MS))
                    soft_go = 1'b1;
            end
            PBR_CSR_TWO:
            begin
                if (!on && hit(s1, c1, `PBR_ON_PRESS_MS))
                    next_state = PBR_ON;
                if (hit(s2, c2, `PBR_LONG_PRESS_MS))
                    soft_go = 1'b1;
            end
            default:
            begin
                next_oe_n = 1'b1;
            end
        endcase
        // debounced opposite level aborts a countdown
        if ((code == PBR_CUST_HI || code == PBR_CUST_LO || code == PBR_CUST_SEAL))
        begin
            if (hit(s1, c1, `PBR_DEBOUNCE_MS))
                next_pend_h = 1'b0;
            if (hit(s2, c2, `PBR_DEBOUNCE_MS))
                next_pend_s = 1'b0;
        end
        if (ins && pin_on_ok)
            next_state = PBR_ON;
        if (on && power_off_request)
            next_state = PBR_OFF;
        else if (on && seal_request && seal_ok)
            next_state = PBR_SEAL;
        if (pend_h && hit(sh, ch, delay_ms(code)))
        begin
            hard_go = 1'b1;
            next_pend_h = 1'b0;
        end
        if (pend_s && hit(ss, cs, delay_ms(code)))
        begin
            soft_go = 1'b1;
            next_pend_s = 1'b0;
        end
        if (soft_go && sys_reset_n)
            next_rst_n = 1'b0;
        if (!sys_reset_n && hit(sr, cr, `PBR_SOFT_PULSE_MS))
            next_rst_n = 1'b1;
        if (hard_go)
        begin
            next_hard = 1'b1;
            next_state = PBR_ON;
            next_pend_h = 1'b0;
            next_pend_s = 1'b0;
            next_rst_n = 1'b1;
        end
        if (code >= PBR_RSV_D)
        begin
            next_pend_h = 1'b0;
            next_pend_s = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_state <= PBR_ON;
            pend_h <= 1'b0;
            pend_s <= 1'b0;
            hard_reset <= 1'b0;
            sys_reset_n <= 1'b1;
            key_mirror_oe_n <= 1'b1;
            key_mirror_output <= 1'b0;
            p1_q <= 1'b0;
            p2_q <= 1'b0;
            chg_q <= 1'b0;
        end
        else
        begin
            power_state <= next_state;
            pend_h <= next_pend_h;
            pend_s <= next_pend_s;
            hard_reset <= next_hard;
            sys_reset_n <= next_rst_n;
            key_mirror_oe_n <= next_oe_n;
            key_mirror_output <= 1'b0;
            p1_q <= pin1;
            p2_q <= pin2;
            chg_q <= charger_supply_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_hard_after_delay: assert property ($rose(hard_reset) |-> $past(pend_h) && $past(sh))
        else $error("hard reset without an expired countdown");
    a_soft_pend_arm: assert property (code == PBR_AON_RISE && $stable(code) && pin2 && !p2_q && !hard_go
        |=> pend_s)
        else $error("rising edge on input two did not arm soft reset");
    a_aon_stays_on: assert property (on && code >= PBR_AON_RISE && code <= PBR_CR_LO && !power_off_request
        |=> power_state != PBR_OFF)
        else $error("always-on mode left power by pin");
    a_key_mirror: assert property (code == PBR_KEY && $stable(code) |=> key_mirror_oe_n == $past(pin1))
        else $error("key mirror does not follow key input");
    a_short_press_on: assert property (code == PBR_KEY && !on && hit(s1, c1, `PBR_SHORT_PRESS_MS)
        |=> on)
        else $error("short key press did not power on");
    a_charger_only: assert property (code == PBR_CUST_HI && power_state == PBR_OFF && !ins
        |=> power_state == PBR_OFF)
        else $error("powered on without charger insertion");
    a_soft_pulse_len: assert property ($rose(sys_reset_n) && !$past(hard_go)
        |-> $past(cr) == pbr_cnt_t'(`PBR_SOFT_PULSE_MS) && $past(sr))
        else $error("soft reset pulse length wrong");
    a_hard_powers_on: assert property (hard_reset |-> on && !pend_h && !pend_s ##1 !hard_reset)
        else $error("hard reset did not restart sequence");
    a_reserved_quiet: assert property (code >= PBR_RSV_D |=> !pend_h && !pend_s ##1 !hard_reset)
        else $error("reserved code produced an action");

endmodule : pbr_ctrl

`default_nettype wire

// ---- hw/pbr_timer.sv ----
// interval counter on the shared millisecond timebase
// assumes tick is a one-cycle pulse from the parent
`default_nettype none

module pbr_timer #(
    parameter int CNT_W = 14
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic tick,
    input wire logic run,
    // result
    output logic [CNT_W-1:0] count,
    output logic step
);

    logic [CNT_W-1:0] next_count;
    logic next_step;

    // restart whenever the qualifying condition drops
    always_comb
    begin
        next_count = count;
        next_step = 1'b0;
        if (!run)
        begin
            next_count = '0;
        end
        else if (tick && count != {CNT_W{1'b1}})
        begin
            next_count = count + CNT_W'(1);
            next_step = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            step <= 1'b0;
        end
        else
        begin
            count <= next_count;
            step <= next_step;
        end
    end

endmodule : pbr_timer

`default_nettype wire

// ---- include/pbr_cfg.svh ----
// constants of the power button and reset controller
// assumes a 100 MHz system clock and a 1 ms timebase tick
`ifndef PBR_CFG_SVH
`define PBR_CFG_SVH

// clock and timebase
`define PBR_CLK_PERIOD_NS 10
`define PBR_TICK_NS 1000000
`define PBR_TICK_CYC (`PBR_TICK_NS / `PBR_CLK_PERIOD_NS)

// intervals in milliseconds, counted in timebase ticks
`define PBR_DEBOUNCE_MS 10
`define PBR_RESET_DELAY_MS 200
`define PBR_SHORT_PRESS_MS 400
`define PBR_ON_PRESS_MS 3000
`define PBR_LONG_PRESS_MS 12000
`define PBR_COUNTDOWN_MS 15000
`define PBR_SOFT_PULSE_MS 10

// interval counter width
`define PBR_CNT_W 14

`endif

// ---- include/pbr_pkg.sv ----
// types of the power button and reset controller
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package pbr_pkg;

    // pin function configuration codes
    typedef enum logic [3:0] {
        PBR_ONOFF_HI = 4'h0,
        PBR_ONOFF_LO = 4'h1,
        PBR_AON_RISE = 4'h2,
        PBR_AON_FALL = 4'h3,
        PBR_CR_HI = 4'h4,
        PBR_CR_LO = 4'h5,
        PBR_KEY = 4'h6,
        PBR_CSR_ONE = 4'h7,
        PBR_CSR_TWO = 4'h8,
        PBR_CUST_HI = 4'h9,
        PBR_CUST_LO = 4'hA,
        PBR_KEY_SEAL = 4'hB,
        PBR_CUST_SEAL = 4'hC,
        PBR_RSV_D = 4'hD,
        PBR_RSV_E = 4'hE,
        PBR_RSV_F = 4'hF
    } pbr_code_t;

    // power states, gray along off, on, seal
    typedef enum logic [1:0] {
        PBR_OFF = 2'h0,
        PBR_ON = 2'h1,
        PBR_SEAL = 2'h3
    } pbr_pwr_t;

endpackage : pbr_pkg

`default_nettype wire

// ---- tb/pbr_button_model.sv ----
// user button, host logic and charger detection at the controller pins
// assumes the bench calls its tasks from one process synced to clk_sys
`default_nettype none

module pbr_button_model #(
    parameter int TICK_CYC = 2
) (
    // clock
    input wire logic clk_sys,
    // open-drain pin two from the controller
    input wire logic key_mirror_output,
    input wire logic key_mirror_oe_n,
    // levels seen by the controller
    output logic pin_one,
    output logic pin_two,
    output logic charger
);
    timeunit 1ns;
    timeprecision 1ps;

    logic two_drv = 1'b1;

    initial
    begin
        pin_one = 1'b0;
        charger = 1'b0;
    end

    // pull-up on pin two, the controller may pull it low
    assign pin_two = key_mirror_oe_n ? two_drv : key_mirror_output;

    ////////////////////////////////////////
    // 0 pin one, 1 pin two, 2 charger
    task automatic drive(input logic [1:0] sel, input logic v);
        @(posedge clk_sys);
        #1;
        case (sel)
            2'h0: pin_one = v;
            2'h1: two_drv = v;
            default: charger = v;
        endcase
    endtask : drive

    // levels stay put for whole milliseconds
    task automatic hold_ms(input int ms);
        repeat (ms * TICK_CYC) @(posedge clk_sys);
        #1;
    endtask : hold_ms

endmodule : pbr_button_model

`default_nettype wire

// ---- tb/pbr_ctrl_tb.sv ----
// bench of the power button and reset controller
// assumes pbr_pkg, pbr_ctrl and the pin model; timebase shortened to 2 cycles
`default_nettype none

module pbr_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pbr_pkg::*;

    localparam int T = 2;
    localparam int LIMIT = 100000;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    pbr_code_t cfg = PBR_RSV_D;
    logic off_req = 1'b0;
    logic seal_req = 1'b0;
    logic pin_one;
    logic pin_two;
    logic charger;
    logic key_out;
    logic key_oe_n;
    pbr_pwr_t pwr_state;
    logic hard_reset;
    logic sys_reset_n;
    logic soft_prev = 1'b1;
    int checks = 0;
    int fail_count = 0;
    int cyc = 0;
    int hard_cnt = 0;
    int soft_cnt = 0;

    pbr_ctrl #(.TICK_CYC(T)) dut_u (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_function_config_code(cfg),
        .power_off_request(off_req),
        .seal_request(seal_req),
        .power_function_input_one(pin_one),
        .power_function_input_two(pin_two),
        .charger_supply_input(charger),
        .key_mirror_output(key_out),
        .key_mirror_oe_n(key_oe_n),
        .power_state(pwr_state),
        .hard_reset(hard_reset),
        .sys_reset_n(sys_reset_n)
    );

    pbr_button_model #(.TICK_CYC(T)) m_u (
        .clk_sys(clk_sys),
        .key_mirror_output(key_out),
        .key_mirror_oe_n(key_oe_n),
        .pin_one(pin_one),
        .pin_two(pin_two),
        .charger(charger)
    );

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////
    // event counters and hang limit
    always @(posedge clk_sys)
    begin
        cyc++;
        if (hard_reset === 1'b1)
            hard_cnt++;
        if (sys_reset_n === 1'b0 && soft_prev === 1'b1)
            soft_cnt++;
        soft_prev = sys_reset_n;
        if (cyc >= LIMIT)
        begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // 0 hard reset, 1 soft reset, 2 power state reached
    function automatic logic hit(input int kind, input pbr_pwr_t st);
        case (kind)
            0: return hard_reset === 1'b1;
            1: return sys_reset_n === 1'b0;
            default: return pwr_state === st;
        endcase
    endfunction : hit

    // action due ms after t0, two ticks of slack plus pipeline
    task automatic expect_at(input int kind, input pbr_pwr_t st, input int ms, input int t0);
        while (cyc - t0 < (ms + 3) * T && !hit(kind, st))
        begin
            @(posedge clk_sys);
            #1;
        end
        check(32'(cyc - t0 >= (ms - 2) * T && hit(kind, st)), 32'h1);
    endtask : expect_at

    task automatic soft_len();
        int t0;
        t0 = cyc;
        while (sys_reset_n === 1'b0 && cyc - t0 < 13 * T)
        begin
            @(posedge clk_sys);
            #1;
        end
        check(32'(cyc - t0 >= 8 * T && cyc - t0 < 13 * T), 32'h1);
    endtask : soft_len

    task automatic set_code(input pbr_code_t c);
        @(posedge clk_sys);
        #1;
        cfg = c;
        repeat (3) @(posedge clk_sys);
    endtask : set_code

    task automatic pulse_req(input logic seal);
        @(posedge clk_sys);
        #1;
        seal_req = seal;
        off_req = !seal;
        @(posedge clk_sys);
        #1;
        seal_req = 1'b0;
        off_req = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : pulse_req

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////
    initial
    begin
        int h;
        int s;
        int len;
        int t0;
        logic act;
        void'($urandom(93));
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        // edge codes 2, 3 and insertion codes 4, 5 on both pins
        for (int c = 2; c <= 5; c++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                act = (c == 2 || c == 4);
                set_code(PBR_RSV_D);
                m_u.drive(2'h0, !act);
                m_u.drive(2'h1, !act);
                m_u.drive(2'h2, 1'b0);
                set_code(pbr_code_t'(c));
                h = hard_cnt;
                s = soft_cnt;
                m_u.drive(2'(p), act);
                if (c >= 4)
                    m_u.drive(2'h2, 1'b1);
                t0 = cyc;
                expect_at(p, PBR_ON, 200, t0);
                if (p == 1)
                    soft_len();
                m_u.hold_ms(20);
                check(32'(hard_cnt - h), 32'(1 - p));
                check(32'(soft_cnt - s), 32'(p));
                check(pwr_state, PBR_ON);
            end
        end
        // reserved codes, random pin and charger activity
        for (int c = 13; c <= 15; c++)
        begin
            set_code(pbr_code_t'(c));
            h = hard_cnt;
            s = soft_cnt;
            repeat (4)
            begin
                m_u.drive(2'($urandom % 3), 1'($urandom));
                m_u.hold_ms(1 + $urandom % 5);
            end
            m_u.hold_ms(220);
            check(32'(hard_cnt - h + soft_cnt - s), 32'h0);
        end
        // key mode
        set_code(PBR_RSV_D);
        m_u.drive(2'h0, 1'b1);
        m_u.drive(2'h1, 1'b1);
        m_u.drive(2'h2, 1'b0);
        set_code(PBR_KEY);
        pulse_req(1'b0);
        check(pwr_state, PBR_OFF);
        m_u.drive(2'h2, 1'b1);
        expect_at(2, PBR_ON, 0, cyc);
        pulse_req(1'b0);
        m_u.drive(2'h2, 1'b0);
        len = 50 + $urandom % 300;
        m_u.drive(2'h0, 1'b0);
        m_u.hold_ms(1);
        check(key_oe_n, 1'b0);
        check(pin_two, 1'b0);
        m_u.hold_ms(len);
        m_u.drive(2'h0, 1'b1);
        m_u.hold_ms(1);
        check(key_oe_n, 1'b1);
        check(pwr_state, PBR_OFF);
        m_u.drive(2'h0, 1'b0);
        t0 = cyc;
        expect_at(2, PBR_ON, 400, t0);
        expect_at(2, PBR_OFF, 12000, t0);
        m_u.drive(2'h0, 1'b1);
        // key mode with seal
        set_code(PBR_KEY_SEAL);
        m_u.drive(2'h2, 1'b1);
        expect_at(2, PBR_ON, 0, cyc);
        pulse_req(1'b1);
        check(pwr_state, PBR_SEAL);
        m_u.drive(2'h0, 1'b0);
        t0 = cyc;
        expect_at(2, PBR_ON, 400, t0);
        m_u.drive(2'h0, 1'b1);
        // countdowns, pin two cancelled, pin one runs out
        set_code(PBR_RSV_D);
        m_u.drive(2'h2, 1'b0);
        m_u.drive(2'h1, 1'b1);
        set_code(PBR_CUST_HI);
        s = soft_cnt;
        m_u.drive(2'h2, 1'b1);
        t0 = cyc;
        m_u.hold_ms(100);
        m_u.drive(2'h1, 1'b0);
        expect_at(0, PBR_ON, 15000, t0);
        check(32'(soft_cnt - s), 32'h0);
        // pin one alone never powers on in charger-only code 1001
        pulse_req(1'b0);
        m_u.drive(2'h0, 1'b0);
        m_u.drive(2'h0, 1'b1);
        m_u.hold_ms(20);
        check(pwr_state, PBR_OFF);
        // level on/off codes, high then low active, soft reset on pin two
        for (int c = 0; c < 2; c++)
        begin
            set_code(PBR_RSV_D);
            m_u.drive(2'h0, 1'(c));
            m_u.drive(2'h1, 1'b1);
            set_code(pbr_code_t'(c));
            m_u.drive(2'h0, 1'(1 - c));
            expect_at(2, PBR_ON, 10, cyc);
            m_u.drive(2'h1, 1'b0);
            expect_at(1, PBR_ON, 10, cyc);
            m_u.drive(2'h1, 1'b1);
            m_u.hold_ms(15);
            m_u.drive(2'h0, 1'(c));
            expect_at(2, PBR_OFF, 10, cyc);
        end
        // long key press powers on, key mirrored
        set_code(PBR_RSV_D);
        m_u.drive(2'h0, 1'b1);
        set_code(PBR_CSR_ONE);
        m_u.drive(2'h0, 1'b0);
        t0 = cyc;
        expect_at(2, PBR_ON, 3000, t0);
        check(key_oe_n, 1'b0);
        m_u.drive(2'h0, 1'b1);
        // separate reset button, no mirror
        set_code(PBR_CSR_TWO);
        m_u.drive(2'h0, 1'b0);
        m_u.drive(2'h1, 1'b0);
        t0 = cyc;
        m_u.hold_ms(1);
        check(key_oe_n, 1'b1);
        m_u.drive(2'h0, 1'b1);
        expect_at(1, PBR_ON, 12000, t0);
        m_u.drive(2'h1, 1'b1);
        // seal allowed, then insertion wakes in inverted code
        set_code(PBR_CUST_SEAL);
        pulse_req(1'b1);
        check(pwr_state, PBR_SEAL);
        set_code(PBR_CUST_LO);
        m_u.drive(2'h2, 1'b0);
        m_u.drive(2'h2, 1'b1);
        expect_at(2, PBR_ON, 0, cyc);
        stop_test();
    end

endmodule : pbr_ctrl_tb

`default_nettype wire
